// ===== prcc_pkg.sv
/*
 * prcc_pkg: constants, register map and carrier types for the root clock control block.
 * Assumes an APB master with 32-bit data and a single 50 MHz system-side clock.
 */
// How it works
// RL1: a locked 160 MHz PLL is one selectable root source for the system clock.
// RL2: the selected root clock may be divided down to save current.
// RL3: software moves to oscillator, programs divider, then reselects the PLL.
// RL4: losing PLL lock raises the PLL interrupt request.
// RL5: software should always enable the PLL interrupt source.
// RL6: the lock-loss handler first moves the system clock to the oscillator.
// RL7: software writes reserved bits with their reset value.
// RL8: write-one-to-clear flags stay readable and clear only on a written one.
// RL9: select code 00 oscillator, 01 PLL, 11 external pin, 10 reserved.
// RL10: divider codes 000..111 divide by 1,2,4,...,128.
// RL11: with the enable set, lock and unlock transitions both interrupt. The code also needs that flag's bit set in the mask register.
// RL12: unlock flag sets on unlock and clears only via its clear bit.
// RL13: the interrupt is a level held while an enabled flag stays set.
package prcc_pkg;

	// register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_DIV = 12'h004;
	localparam logic [11:0] OFS_STAT = 12'h008;
	localparam logic [11:0] OFS_MASK = 12'h00C;

	// control register fields
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_IE_BIT = 9;
	localparam logic [15:0] CTRL_RST = 16'h043D;
	localparam logic [15:0] CTRL_WMASK = 16'h0FFF;

	// divider register fields
	localparam int DIV_SYS_LSB = 0;
	localparam logic [15:0] DIV_RST = 16'h0048;
	localparam logic [15:0] DIV_WMASK = 16'h01FF;

	// status register fields
	localparam int STAT_LOCK_BIT = 3;
	localparam int STAT_UNLOCK_BIT = 4;
	localparam logic [1:0] STAT_RST = 2'h3;
	localparam logic [1:0] MASK_RST = 2'h3;

	// root select codes
	localparam logic [1:0] SEL_OSC = 2'h0;
	localparam logic [1:0] SEL_PLL = 2'h1;
	localparam logic [1:0] SEL_EXT = 2'h3;

	localparam int PLL_MHZ = 160;

	// sticky event flags, bit 0 lock, bit 1 unlock
	typedef struct packed {
		logic unlock;
		logic lock;
	} prcc_flags_t;

	// root clock choice and system clock divider presented to the clock tree
	typedef struct packed {
		logic [1:0] root_clock_select;
		logic [2:0] system_clock_divider;
	} prcc_clk_cfg_t;

endpackage

// ===== prcc_top.sv
/*
 * prcc_top: APB register slave, lock event detection, root select and system clock divide enable.
 * Assumes pll_locked_i comes from the PLL's own domain and ext_clk_i is a slow pin sampled here.
 */
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module prcc_top (
	input wire logic clk_i, // 50 MHz clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic ce_i, // clock enable, freezes state when low
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb enable
	input wire logic pwrite_i, // apb write
	input wire logic [11:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error
	input wire logic pll_locked_i, // pll lock detector level
	input wire logic osc_clk_i, // oscillator tick sample
	input wire logic pll_clk_i, // pll tick sample
	input wire logic ext_clk_i, // external clock pin
	output prcc_pkg::prcc_clk_cfg_t clk_cfg_o, // root select and divider
	output logic root_clk_o, // selected root clock level
	output logic sys_clk_en_o, // divided system clock enable pulse
	output logic pll_irq_o // pll interrupt request level
);
	logic [15:0] ctrl, next_ctrl;
	logic [15:0] div, next_div;
	prcc_pkg::prcc_flags_t flags, next_flags;
	prcc_pkg::prcc_flags_t mask, next_mask;
	logic [2:0] lock_sync, next_lock_sync;
	logic [2:0] ext_sync, next_ext_sync;
	logic lock_q, next_lock_q;
	logic ext_q, next_ext_q;
	logic [6:0] div_cnt, next_div_cnt;
	logic [31:0] rdata, next_rdata;
	logic root_q, next_root_q;
	logic wr_en, rd_en, addr_ok, rise, fall;
	logic hit_ctrl, hit_div, hit_stat, hit_mask;

	// all registers answer in one access cycle, no wait states
	assign pready_o = 1'b1;
	assign wr_en = psel_i & penable_i & pwrite_i & ce_i;
	// read data is fetched in the setup cycle, so it already stands through the access cycle
	assign rd_en = psel_i & ~penable_i & ~pwrite_i & ce_i;

	// register decode, shared by the write and error paths; the read path decodes paddr_i in its own case
	assign hit_ctrl = (paddr_i == prcc_pkg::OFS_CTRL);
	assign hit_div = (paddr_i == prcc_pkg::OFS_DIV);
	assign hit_stat = (paddr_i == prcc_pkg::OFS_STAT);
	assign hit_mask = (paddr_i == prcc_pkg::OFS_MASK);
	assign addr_ok = hit_ctrl | hit_div | hit_stat | hit_mask;
	// an unmapped offset is refused in the access phase
	assign pslverr_o = psel_i & penable_i & ~addr_ok;
	// read data comes straight from its register
	assign prdata_o = rdata;

	// lock edges are counted only once stages two and three agree
	assign rise = lock_sync[2] & lock_sync[1] & ~lock_q;
	assign fall = ~lock_sync[2] & ~lock_sync[1] & lock_q;

	// divide ratio is two to the power of the code
	function automatic logic [6:0] div_limit(input logic [2:0] code);
		div_limit = 7'((8'h01 << code) - 8'h01); // [RL10]
	endfunction

	// next synchroniser state; a one-stage glitch never reaches the agreed level
	always_comb begin
		next_lock_sync = {lock_sync[1:0], pll_locked_i};
		next_ext_sync = {ext_sync[1:0], ext_clk_i};
		next_lock_q = lock_q;
		next_ext_q = ext_q;
		if (lock_sync[2] == lock_sync[1]) begin
			next_lock_q = lock_sync[2];
		end
		if (ext_sync[2] == ext_sync[1]) begin
			next_ext_q = ext_sync[2];
		end
	end

	// lock chain starts at the locked level, so a running pll shows no false edge after reset
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			lock_sync <= 3'h7;
			ext_sync <= 3'h0;
			lock_q <= 1'b1;
			ext_q <= 1'b0;
		end else if (ce_i) begin
			lock_sync <= next_lock_sync;
			ext_sync <= next_ext_sync;
			lock_q <= next_lock_q;
			ext_q <= next_ext_q;
		end
	end

	// next control, divider and mask words; read-only upper bits stay zero
	always_comb begin
		next_ctrl = ctrl;
		next_div = div;
		next_mask = mask;
		if (wr_en && hit_ctrl) begin
			next_ctrl = pwdata_i[15:0] & prcc_pkg::CTRL_WMASK; // [RL9]
		end
		if (wr_en && hit_div) begin
			next_div = pwdata_i[15:0] & prcc_pkg::DIV_WMASK; // [RL2]
		end
		// the mask shares the status layout, so one word serves both registers
		if (wr_en && hit_mask) begin
			next_mask = prcc_pkg::prcc_flags_t'(pwdata_i[prcc_pkg::STAT_UNLOCK_BIT:prcc_pkg::STAT_LOCK_BIT]);
		end
	end

	// control words, frozen while the clock enable is low
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl <= prcc_pkg::CTRL_RST;
			div <= prcc_pkg::DIV_RST;
			mask <= prcc_pkg::prcc_flags_t'(prcc_pkg::MASK_RST);
		end else if (ce_i) begin
			ctrl <= next_ctrl;
			div <= next_div;
			mask <= next_mask;
		end
	end

	// next sticky flags; a written one clears, zeros leave the flag alone
	always_comb begin
		next_flags = flags;
		if (wr_en && hit_stat) begin
			if (pwdata_i[prcc_pkg::STAT_LOCK_BIT]) begin
				next_flags.lock = 1'b0; // [RL8]
			end
			if (pwdata_i[prcc_pkg::STAT_UNLOCK_BIT]) begin
				next_flags.unlock = 1'b0; // [RL12]
			end
		end
		// set wins over a clear in the same cycle, so an event is never lost
		if (rise) begin
			next_flags.lock = 1'b1; // [RL11]
		end
		if (fall) begin
			next_flags.unlock = 1'b1; // [RL4] [RL12]
		end
	end

	// sticky flags, both set out of reset while the lock state is not yet known
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			flags <= prcc_pkg::prcc_flags_t'(prcc_pkg::STAT_RST);
		end else if (ce_i) begin
			flags <= next_flags;
		end
	end

	// next read word; unmapped offsets read zero
	always_comb begin
		next_rdata = rdata;
		if (rd_en) begin
			unique case (paddr_i)
				prcc_pkg::OFS_CTRL: next_rdata = {16'h0000, ctrl};
				prcc_pkg::OFS_DIV: next_rdata = {16'h0000, div};
				prcc_pkg::OFS_STAT: next_rdata = {27'h0, flags.unlock, flags.lock, 3'h0}; // [RL8]
				prcc_pkg::OFS_MASK: next_rdata = {27'h0, mask.unlock, mask.lock, 3'h0};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	// read register, frozen while the clock enable is low
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata <= 32'h00000000;
		end else if (ce_i) begin
			rdata <= next_rdata;
		end
	end

	// level irq while an enabled, unmasked flag stays set
	assign pll_irq_o = ctrl[prcc_pkg::CTRL_IE_BIT] & |(flags & mask); // [RL11] [RL13]

	// configuration word as the clock tree sees it
	assign clk_cfg_o.root_clock_select = ctrl[prcc_pkg::CTRL_SEL_LSB +: 2];
	assign clk_cfg_o.system_clock_divider = div[prcc_pkg::DIV_SYS_LSB +: 3];

	// root mux; the reserved select code falls back to the oscillator
	always_comb begin
		next_root_q = osc_clk_i;
		unique case (clk_cfg_o.root_clock_select)
			prcc_pkg::SEL_PLL: next_root_q = pll_clk_i; // [RL1]
			prcc_pkg::SEL_EXT: next_root_q = ext_q; // [RL9]
			default: next_root_q = osc_clk_i; // [RL9]
		endcase
	end

	// the registered root level costs one cycle but keeps the mux output free of glitches
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			root_q <= 1'b0;
		end else if (ce_i) begin
			root_q <= next_root_q;
		end
	end

	// divide counter; >= rather than == lets a smaller ratio wrap at once
	always_comb begin
		next_div_cnt = div_cnt + 7'h01;
		if (div_cnt >= div_limit(clk_cfg_o.system_clock_divider)) begin
			next_div_cnt = 7'h00; // [RL2]
		end
	end

	// a divider change takes effect in the next cycle, as the compare uses the new limit, so the safe order of [RL3] still holds
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			div_cnt <= 7'h00;
		end else if (ce_i) begin
			div_cnt <= next_div_cnt;
		end
	end

	// outputs; the enable pulse is gated so a frozen block emits no ticks
	assign root_clk_o = root_q;
	assign sys_clk_en_o = ce_i & (div_cnt == 7'h00);

endmodule // prcc_top

// ===== prcc_monitor.sv
/* prcc_monitor: port assertions for prcc_top.
   assumes one clk_i domain and a synchronous low reset. */
`timescale 1ns/1ps
module prcc_monitor (
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic ce_i, // enable
	input wire logic psel_i, // select
	input wire logic penable_i, // access
	input wire logic pwrite_i, // write
	input wire logic [11:0] paddr_i, // address
	input wire logic [31:0] pwdata_i, // data
	input wire logic pready_o, // ready
	input wire logic pslverr_o, // error
	input wire prcc_pkg::prcc_clk_cfg_t clk_cfg_o, // config
	input wire logic sys_clk_en_o, // divided enable
	input wire logic pll_irq_o // irq
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic acc, map, wr;
	// decode; only four aligned words below 0x010 exist
	assign acc = psel_i && penable_i;
	assign map = paddr_i[11:4] == 8'h00 && paddr_i[1:0] == 2'h0;
	assign wr = acc && pwrite_i && ce_i;
	a_ready_high: assert property (acc |-> pready_o) else $error("ready low");
	a_err_unmapped: assert property (acc && !map |-> pslverr_o) else $error("no error");
	a_err_mapped: assert property (acc && map |-> !pslverr_o) else $error("false error");
	a_sel_write: assert property (wr && paddr_i == prcc_pkg::OFS_CTRL |=>
		clk_cfg_o.root_clock_select == $past(pwdata_i[1:0])) else $error("select");
	a_div_write: assert property (wr && paddr_i == prcc_pkg::OFS_DIV |=>
		clk_cfg_o.system_clock_divider == $past(pwdata_i[2:0])) else $error("divider");
	a_ce_freeze: assert property (!ce_i |=> $stable(clk_cfg_o)) else $error("frozen");
	a_irq_off: assert property (wr && paddr_i == 12'h000 && !pwdata_i[9] |=> !pll_irq_o)
		else $error("irq");
	a_div_one: assert property (clk_cfg_o.system_clock_divider == 3'h0 [*2] |-> sys_clk_en_o == ce_i)
		else $error("div one");
	c_ctrl: cover property (wr && paddr_i == prcc_pkg::OFS_CTRL);
	c_irq: cover property (pll_irq_o);
	c_bad: cover property (acc && !map);
endmodule // prcc_monitor
bind prcc_top prcc_monitor u_mon (.*);

// ===== prcc_top_tb.sv
/* prcc_top_tb: register, divider, flag and irq checks against a bench model.
   assumes the hand-over: ready always high, flags seen within ten cycles. */
`timescale 1ns/1ps
module prcc_top_tb;
	logic clk_i, rst_n_i, ce_i, psel_i, penable_i, pwrite_i, pll_locked_i, osc_clk_i, pll_clk_i, ext_clk_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, r;
	logic pready_o, pslverr_o, root_clk_o, sys_clk_en_o, pll_irq_o;
	prcc_pkg::prcc_clk_cfg_t clk_cfg_o;
	int fails, tests_run, n, ctrl;
	logic err, exp_root;
	logic [1:0] m_sel;
	localparam logic [11:0] AC = prcc_pkg::OFS_CTRL;
	localparam logic [11:0] AS = prcc_pkg::OFS_STAT;
	prcc_top u_prcc_top (.*);
	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end
	// random tick samples; the model root flop follows the model select, frozen like the design
	always @(posedge clk_i) begin
		if (ce_i) exp_root <= (m_sel == prcc_pkg::SEL_PLL) ? pll_clk_i : osc_clk_i;
		{osc_clk_i, pll_clk_i, ext_clk_i} <= 3'($urandom);
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	// setup then access, held until ready is seen high
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
		@(posedge clk_i);
		penable_i <= 1'h1;
		do @(posedge clk_i); while (pready_o !== 1'h1);
		r = prdata_o;
		err = pslverr_o;
		// the model select follows a control write that landed
		if (w && a == AC && ce_i) m_sel <= d[1:0];
		{psel_i, penable_i} <= 2'h0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk("read", e, r);
		chk("slverr", {31'h0, a > prcc_pkg::OFS_MASK || a[1:0] != 2'h0}, {31'h0, err});
	endtask
	task automatic irq(input logic e);
		@(negedge clk_i);
		chk("irq", e, pll_irq_o);
	endtask
	task automatic lock(input logic v);
		pll_locked_i <= v;
		repeat (10) @(posedge clk_i);
	endtask
	task automatic stop_test;
		if (fails == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(11));
		{rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{ce_i, pll_locked_i} = 2'h3;
		m_sel = prcc_pkg::CTRL_RST[1:0];
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'h1;
		rd(AC, 32'h043D);
		rd(prcc_pkg::OFS_DIV, 32'h0048);
		rd(AS, 32'h0018);
		rd(prcc_pkg::OFS_MASK, 32'h0018);
		rd(12'h010, 32'h0);
		// every select code, random clock-out and analog bits; reserved bits and irq enable kept zero
		for (int i = 0; i < 4; i++) begin
			ctrl = ($urandom & 32'h0C3C) | i;
			bus(1'h1, AC, ctrl);
			rd(AC, ctrl & 32'h0FFF);
			chk("select", i, {30'h0, clk_cfg_o.root_clock_select});
			// the external pin passes a synchroniser, so only oscillator and pll ticks are traced
			if (i != 3) repeat (8) @(negedge clk_i) chk("root", exp_root, root_clk_o);
		end
		// each divider code, changed the safe way round from the pll; pulses in 128 cycles is 128 >> code
		for (int i = 0; i < 8; i++) begin
			bus(1'h1, AC, 32'h0400);
			bus(1'h1, prcc_pkg::OFS_DIV, 32'h0048 | i);
			bus(1'h1, AC, 32'h0401);
			chk("divider", i, {29'h0, clk_cfg_o.system_clock_divider});
			repeat (130) @(posedge clk_i);
			n = 0;
			repeat (128) @(negedge clk_i) n += sys_clk_en_o;
			chk("pulses", 128 >> i, n);
		end
		// a write with the enable low must not land
		@(posedge clk_i) ce_i <= 1'h0;
		bus(1'h1, AC, 32'h0600);
		ce_i <= 1'h1;
		rd(AC, 32'h0401);
		bus(1'h1, AS, 32'h0018);
		rd(AS, 32'h0);
		bus(1'h1, AC, 32'h0601);
		lock(1'h0);
		rd(AS, 32'h0010);
		irq(1'h1);
		// the handler first moves the system clock back to the oscillator
		bus(1'h1, AC, 32'h0600);
		rd(AC, 32'h0600);
		lock(1'h1);
		bus(1'h1, AS, 32'h0);
		rd(AS, 32'h0018);
		bus(1'h1, AS, 32'h0010);
		rd(AS, 32'h0008);
		irq(1'h1);
		bus(1'h1, AS, 32'h0008);
		irq(1'h0);
		// unlock masked off: flag still sets, no request
		bus(1'h1, prcc_pkg::OFS_MASK, 32'h8);
		rd(prcc_pkg::OFS_MASK, 32'h0008);
		lock(1'h0);
		rd(AS, 32'h0010);
		irq(1'h0);
		stop_test;
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		fails++;
		stop_test;
	end
endmodule // prcc_top_tb
